// >>> core/snv_core.sv
// Serial memory slave: frame sequencer, status register, 32K x 8 array.
// Assumes pins arrive asynchronously and sck runs well below mclk / 8.
`timescale 1ns/1ps
`default_nettype none

// Write-commit buffer between the serial side and the array port
module snv_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    logic doPush;
    logic doPop;

    // Honest flags straight from the occupancy count
    assign inReady = (count != (PW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = store[rdPtr];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    // Pointer and count update
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) wrPtr <= PW'(wrPtr + 1'b1);
            if (doPop) rdPtr <= PW'(rdPtr + 1'b1);
            count <= (PW+1)'(count + doPush - doPop);
        end
    end

    // Storage holds no control state, so it needs no reset
    always_ff @(posedge mclk) begin
        if (doPush) store[wrPtr] <= inData;
    end
endmodule // snv_fifo

// Overview of operation
// RULE1 - 8-bit status: enable, two guards, latch
// RULE2 - Bits 0, 4-6 ignore writes, read zero
// RULE3 - Latch clear at reset; one permits writes
// RULE4 - Only the set command sets the latch
// RULE5 - Guard bits survive power cycling
// RULE6 - Guard value selects protected top range
// RULE7 - Enabled low protect pin blocks status write
// RULE8 - Latch and guards alone gate array writes
// RULE9 - Protect pin never blocks array writes
// RULE10 - Status read returns exactly one byte
// RULE11 - Status write updates three bits, clears latch
// RULE12 - Master sets latch first, pin held high
// RULE13 - Two address bytes, top bit ignored
// RULE14 - Write burst increments, wraps to zero
// RULE15 - Each full byte committed, partial dropped
// RULE16 - Guarded address stops increment, drops bytes
// RULE17 - Select rise ends write burst
// RULE18 - Read drives MSB first, sequential, wraps
// RULE19 - Select rise ends read, floats output
// RULE20 - Fast read adds one dummy byte
// RULE21 - Fast read ignores input, wraps, floats
// RULE22 - Register command codes as listed
// RULE23 - Memory read and write command codes
// RULE24 - Latch clears at select rise after commands
// RULE25 - First byte is command; unknown ignored
// RULE26 - Write with latch clear changes nothing
// RULE27 - Guard compare uses 15-bit address
module snv_core
    import snv_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Serial link pins, asynchronous to mclk
    input wire logic sckIn,
    input wire logic csN,
    input wire logic siIn,
    input wire logic protectN,
    // Serial output, enable active low
    output logic soOut,
    output logic soOeN
);
    typedef struct packed {
        logic sckS1, sckS2, sckS3;
        logic csS1, csS2, csS3;
        logic siS1, siS2;
        logic wpS1, wpS2;
        snv_state_t state;
        logic [7:0] op;
        logic [2:0] bitCnt;
        logic [6:0] rx;
        logic [ADDR_W-1:0] addr;
        logic write_enable_latch;
        logic clrPend;
        logic stopped;
        logic fetch;
        logic soOut;
        logic soOeN;
    } snv_regs_t;

    snv_regs_t r;
    snv_regs_t next_r;
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] memQ;
    logic ppe;
    logic [1:0] guard;
    logic [7:0] statusWord;
    logic [7:0] srcByte;
    logic [7:0] rxByte;
    logic sckRise, sckFall, csRise, csFall, byteDone;
    logic guarded, statusWrite, pushValid, pushReady;
    logic drainValid, drainReady;
    logic [FIFO_W-1:0] drainData;

    // Edge detection looks only at second and third sync stages
    assign csFall = ~r.csS2 & r.csS3;
    assign csRise = r.csS2 & ~r.csS3;
    assign sckRise = r.sckS2 & ~r.sckS3 & ~r.csS2 & ~csFall;
    assign sckFall = ~r.sckS2 & r.sckS3 & ~r.csS2 & ~csFall;
    assign rxByte = {r.rx, r.siS2};
    assign byteDone = sckRise && (r.bitCnt == 3'h7);

    // RULE1 status layout
    // RULE2 unused bits tied low
    assign statusWord = {ppe, 3'h0, guard, r.write_enable_latch, 1'h0};
    assign srcByte = (r.state == S_STAT_RD) ? statusWord : memQ;

    // RULE6 guard ranges
    // RULE27 15-bit compare
    always_comb begin
        case (guard)
            2'h1: guarded = (r.addr >= GUARD_QUARTER);
            2'h2: guarded = (r.addr >= GUARD_HALF);
            2'h3: guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    end

    // RULE8 latch and guards gate pushes
    // RULE9 protect pin not consulted here
    // RULE26 latch clear drops the byte
    assign pushValid = byteDone && (r.state == S_WRITE) && r.write_enable_latch
        && !r.stopped && !guarded;

    // RULE7 enabled low pin blocks status write
    // RULE11 needs the latch set
    assign statusWrite = byteDone && (r.state == S_STAT_WR) && r.write_enable_latch
        && !(ppe && !r.wpS2);

    // Frame sequencer
    always_comb begin
        next_r = r;
        next_r.fetch = 1'b0;
        next_r.sckS1 = sckIn;
        next_r.sckS2 = r.sckS1;
        next_r.sckS3 = r.sckS2;
        next_r.csS1 = csN;
        next_r.csS2 = r.csS1;
        next_r.csS3 = r.csS2;
        next_r.siS1 = siIn;
        next_r.siS2 = r.siS1;
        next_r.wpS1 = protectN;
        next_r.wpS2 = r.wpS1;
        if (csRise) begin
            // RULE17 select rise ends burst
            // RULE19 output floats again
            next_r.state = S_IDLE;
            next_r.soOeN = 1'b1;
            // RULE24 deferred latch clear
            if (r.clrPend) next_r.write_enable_latch = 1'b0;
            next_r.clrPend = 1'b0;
        end else if (csFall) begin
            // RULE25 first byte is the command
            next_r.state = S_OPCODE;
            next_r.bitCnt = 3'h0;
            next_r.stopped = 1'b0;
        end else begin
            // RULE18 MSB first, bit changes on falling edge
            if (sckFall) next_r.soOut = srcByte[~r.bitCnt];
            if (sckRise) begin
                next_r.rx = rxByte[6:0];
                next_r.bitCnt = 3'(r.bitCnt + 1'b1);
            end
            if (byteDone) begin
                case (r.state)
                    S_OPCODE: begin
                        next_r.op = rxByte;
                        next_r.state = S_IGNORE;
                        // RULE22 register commands
                        // RULE23 memory commands
                        case (rxByte)
                            OP_LATCH_SET: begin
                                // RULE4 only this command sets it
                                next_r.write_enable_latch = 1'b1;
                                next_r.clrPend = 1'b0;
                            end
                            OP_LATCH_CLEAR: next_r.clrPend = 1'b1;
                            OP_STATUS_READ: begin
                                next_r.state = S_STAT_RD;
                                next_r.soOeN = 1'b0;
                            end
                            OP_STATUS_WRITE: begin
                                next_r.state = S_STAT_WR;
                                next_r.clrPend = 1'b1;
                            end
                            OP_WRITE: begin
                                next_r.state = S_ADDR_HI;
                                next_r.clrPend = 1'b1;
                            end
                            OP_READ, OP_FAST_READ: next_r.state = S_ADDR_HI;
                            // RULE25 unknown command, input ignored
                            default: next_r.state = S_IGNORE;
                        endcase
                    end
                    S_ADDR_HI: begin
                        // RULE13 top address bit dropped
                        next_r.addr[ADDR_W-1:8] = rxByte[6:0];
                        next_r.state = S_ADDR_LO;
                    end
                    S_ADDR_LO: begin
                        next_r.addr[7:0] = rxByte;
                        if (r.op == OP_WRITE) begin
                            next_r.state = S_WRITE;
                        end else if (r.op == OP_FAST_READ) begin
                            next_r.state = S_DUMMY;
                        end else begin
                            next_r.state = S_READ;
                            next_r.fetch = 1'b1;
                            next_r.soOeN = 1'b0;
                        end
                    end
                    S_DUMMY: begin
                        // RULE20 dummy byte then plain read
                        next_r.state = S_READ;
                        next_r.fetch = 1'b1;
                        next_r.soOeN = 1'b0;
                    end
                    S_READ: begin
                        // RULE21 input ignored, address wraps
                        next_r.addr = ADDR_W'(r.addr + 1'b1);
                        next_r.fetch = 1'b1;
                    end
                    S_WRITE: begin
                        // RULE16 guarded address freezes burst
                        if (r.write_enable_latch && guarded) next_r.stopped = 1'b1;
                        // RULE14 increment with natural wrap
                        if (pushValid && pushReady) begin
                            next_r.addr = ADDR_W'(r.addr + 1'b1);
                        end
                    end
                    S_STAT_RD: begin
                        // RULE10 one status byte only
                        next_r.state = S_IGNORE;
                        next_r.soOeN = 1'b1;
                    end
                    S_STAT_WR: next_r.state = S_IGNORE;
                    default: next_r.state = r.state;
                endcase
            end
        end
    end

    // RULE3 latch and control clear on reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.sckS1 <= 1'b0;
            r.csS1 <= 1'b1;
            r.csS2 <= 1'b1;
            r.csS3 <= 1'b1;
            r.wpS1 <= 1'b1;
            r.wpS2 <= 1'b1;
            r.state <= S_IDLE;
            r.write_enable_latch <= STATUS_RESET[ST_WEL];
            r.soOeN <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // RULE5 guard and enable bits kept out of reset, like the array
    // RULE11 status write updates three bits
    always_ff @(posedge mclk) begin
        if (statusWrite) begin
            ppe <= rxByte[ST_PPE];
            guard <= {rxByte[ST_BG_HI], rxByte[ST_BG_LO]};
        end
    end

    // RULE15 only complete bytes reach the buffer
    snv_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) uCommit (
        .mclk(mclk),
        .rstn(rstn),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData({r.addr, rxByte}),
        .outValid(drainValid),
        .outReady(drainReady),
        .outData(drainData)
    );

    // Single array port: a read fetch stalls the write drain one cycle
    assign drainReady = ~r.fetch;

    // Array port
    always_ff @(posedge mclk) begin
        if (r.fetch) memQ <= mem[r.addr];
        if (drainValid && drainReady) begin
            mem[drainData[FIFO_W-1:8]] <= drainData[7:0];
        end
    end

    assign soOut = r.soOut;
    assign soOeN = r.soOeN;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_frameEnd;
        csRise && r.clrPend;
    endsequence
    sequence s_lastRead;
        byteDone && r.state == S_READ && r.addr == ADDR_LAST;
    endsequence

    property p_statusZero;
        statusWord[0] == 1'b0 && statusWord[6:4] == 3'h0;
    endproperty
    a_statusZero: assert property (p_statusZero) // RULE2
        else $error("Unused status bits not zero");

    property p_latchClear;
        s_frameEnd |=> !r.write_enable_latch;
    endproperty
    a_latchClear: assert property (p_latchClear) // RULE24
        else $error("Latch not cleared at select rise");

    property p_latchSet;
        byteDone && r.state == S_OPCODE && rxByte == OP_LATCH_SET
            |=> r.write_enable_latch ##1 (r.write_enable_latch || csRise);
    endproperty
    a_latchSet: assert property (p_latchSet) // RULE4
        else $error("Latch not set by set command");

    property p_floatAfterRise;
        csRise |=> soOeN [*3];
    endproperty
    a_floatAfterRise: assert property (p_floatAfterRise) // RULE19
        else $error("Output driven after select rise");

    property p_noGuardedPush;
        pushValid |-> r.write_enable_latch && (guard == 2'h0 || (guard == 2'h1 && r.addr <
            GUARD_QUARTER) || (guard == 2'h2 && r.addr < GUARD_HALF));
    endproperty
    a_noGuardedPush: assert property (p_noGuardedPush) // RULE8
        else $error("Write pushed into guarded or latched-off range");

    property p_readWrap;
        s_lastRead |=> r.addr == '0 && r.fetch;
    endproperty
    a_readWrap: assert property (p_readWrap) // RULE18
        else $error("Read address failed to wrap");

    property p_statusBlocked;
        byteDone && r.state == S_STAT_WR && ppe && !r.wpS2
            |=> $stable(guard) && $stable(ppe);
    endproperty
    a_statusBlocked: assert property (p_statusBlocked) // RULE7
        else $error("Status written while pin protection active");

    property p_ignoreFloats;
        r.state == S_IGNORE |-> soOeN;
    endproperty
    a_ignoreFloats: assert property (p_ignoreFloats) // RULE25
        else $error("Output driven during ignored frame");

    property p_stoppedHolds;
        r.stopped && r.state == S_WRITE && !csRise |=> $stable(r.addr);
    endproperty
    a_stoppedHolds: assert property (p_stoppedHolds) // RULE16
        else $error("Address moved after guarded stop");
endmodule // snv_core

`default_nettype wire

// >>> core/snv_pkg.sv
// Shared constants and types for the serial nonvolatile memory slave.
// Assumes one 100 MHz system clock samples all serial pins.
package snv_pkg;

    // Command codes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_WRITE = 8'h02;

    // Array geometry and buffering
    localparam int ADDR_W = 15;
    localparam int MEM_DEPTH = 32768;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = ADDR_W + 8;

    // Status register bit positions and reset value
    localparam int ST_PPE = 7;
    localparam int ST_BG_HI = 3;
    localparam int ST_BG_LO = 2;
    localparam int ST_WEL = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Lowest guarded address for block-guard settings 1 and 2, and the last address
    localparam logic [ADDR_W-1:0] GUARD_QUARTER = 15'h6000;
    localparam logic [ADDR_W-1:0] GUARD_HALF = 15'h4000;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 15'h7FFF;

    // Frame sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_OPCODE, S_ADDR_HI, S_ADDR_LO, S_DUMMY,
        S_READ, S_WRITE, S_STAT_RD, S_STAT_WR, S_IGNORE
    } snv_state_t;

endpackage

// >>> tb/snv_spi_master.sv
// Bus master model for the serial memory slave: frames and mode 0 bytes.
// Assumes one calling process and a 100 MHz mclk; sck idles low.
`timescale 1ns/1ps
`default_nettype none

module snv_spi_master (
    // Clock and pacing
    input wire logic mclk,
    input wire logic slow,
    // Serial pins
    input wire logic soLine,
    output var logic sckIn,
    output var logic csN,
    output var logic siIn
);
    // Alternating 6/7 cycle high phase averages a 115 ns period, 185 ns when slow
    logic odd = 1'b0;

    // Pins idle before the first frame
    initial begin
        sckIn = 1'b0;
        csN = 1'b1;
        siIn = 1'b0;
    end

    // Select low, then a settling gap for the sync pipeline
    task automatic open();
        @(posedge mclk);
        csN <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    // Select high; data line keeps moving so it is never mistaken for data
    task automatic close();
        repeat (4) @(posedge mclk);
        csN <= 1'b1;
        siIn <= ~siIn;
        repeat (12) @(posedge mclk);
    endtask

    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i >= 8 - n; i--) begin
            @(posedge mclk);
            sckIn <= 1'b0;
            siIn <= tx[i];
            repeat (slow ? 12 : 5) @(posedge mclk);
            sckIn <= 1'b1;
            rx = {rx[6:0], soLine};
            repeat (5 + int'(odd)) @(posedge mclk);
            odd = ~odd;
        end
        @(posedge mclk);
        sckIn <= 1'b0;
    endtask
endmodule // snv_spi_master
`default_nettype wire

// >>> tb/snv_core_tb.sv
// Testbench for the serial memory slave: status, protection, array paths.
// Assumes the master model beside it and a 100 MHz mclk.
`timescale 1ns/1ps
`default_nettype none

module snv_core_tb
    import snv_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic protectN = 1'b1;
    logic slow = 1'b0;
    logic soLast = 1'b0;
    logic sckIn, csN, siIn, soOut, soOeN, soLine;
    logic [7:0] rx;
    logic [7:0] g;
    logic [15:0] lo;
    logic [7:0] badOps[3] = '{8'hB9, 8'h9F, 8'hC3};
    int mismatches = 0;
    int nTests = 0;

    // Clock, 10 ns period
    always #5 mclk = ~mclk;

    // A floated line shows the inverse of its last driven level
    always @(posedge mclk) begin
        if (!soOeN) begin
            soLast <= soOut;
        end
    end
    assign soLine = soOeN ? ~soLast : soOut;

    snv_core i_snv_core (
        .mclk(mclk), .rstn(rstn), .sckIn(sckIn), .csN(csN), .siIn(siIn),
        .protectN(protectN), .soOut(soOut), .soOeN(soOeN)
    );

    snv_spi_master i_snv_spi_master (
        .mclk(mclk), .slow(slow), .soLine(soLine), .sckIn(sckIn),
        .csN(csN), .siIn(siIn)
    );

    // Compare and count
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One byte through the master model
    task automatic sb(input logic [7:0] tx, output logic [7:0] r,
                      input int n = 8);
        i_snv_spi_master.shift(tx, n, r);
    endtask

    // Single opcode frame
    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        i_snv_spi_master.open();
        sb(op, r);
        i_snv_spi_master.close();
    endtask

    // latch set in its own frame
    task automatic wrStat(input logic [7:0] v, input bit en = 1'b1);
        logic [7:0] r;
        if (en) begin
            cmd(OP_LATCH_SET);
        end
        i_snv_spi_master.open();
        sb(OP_STATUS_WRITE, r);
        sb(v, r);
        i_snv_spi_master.close();
    endtask

    // Status read plus one extra byte that must stay floated
    task automatic rdStat(input logic [7:0] exp);
        logic [7:0] r;
        i_snv_spi_master.open();
        sb(OP_STATUS_READ, r);
        sb(8'hA5, r);
        check("status", r, exp);
        check("float after status", {7'h00, soOeN}, 8'h01);
        sb(8'h5A, r);
        check("float extra byte", {7'h00, soOeN}, 8'h01);
        i_snv_spi_master.close();
    endtask

    task automatic memWr(input logic [15:0] a, input logic [7:0] d[$],
                         input int n = 8, input bit en = 1'b1);
        logic [7:0] r;
        if (en) begin
            cmd(OP_LATCH_SET);
        end
        i_snv_spi_master.open();
        sb(OP_WRITE, r);
        sb(a[15:8], r);
        sb(a[7:0], r);
        foreach (d[i]) begin
            sb(d[i], r, (i == d.size() - 1) ? n : 8);
        end
        check("float in write", {7'h00, soOeN}, 8'h01);
        i_snv_spi_master.close();
    endtask

    // Data in reads keeps toggling, so ignoring it is exercised
    task automatic memRd(input bit fast, input logic [15:0] a,
                         input logic [7:0] e[$]);
        logic [7:0] r;
        i_snv_spi_master.open();
        sb(fast ? OP_FAST_READ : OP_READ, r);
        sb(a[15:8], r);
        sb(a[7:0], r);
        if (fast) begin
            sb(8'h00, r);
        end
        foreach (e[i]) begin
            sb(8'hA5, r);
            check("read data", r, e[i]);
        end
        i_snv_spi_master.close();
        check("float after read", {7'h00, soOeN}, 8'h01);
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog, well above the expected 20k cycles
    initial begin
        repeat (90000) @(posedge mclk);
        mismatches++;
        conclude();
    end

    // Test sequence
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        check("float at reset", {7'h00, soOeN}, 8'h01);
        wrStat(8'h00);
        rdStat(8'h00);
        cmd(OP_LATCH_SET);
        rdStat(8'h02);
        cmd(OP_LATCH_CLEAR);
        rdStat(8'h00);
        wrStat(8'h8C, 1'b0);
        rdStat(8'h00);
        wrStat(8'hFF);
        rdStat(8'h8C);
        wrStat(8'h00);
        memWr(16'h8010, '{8'h11, 8'h22, 8'h5A});
        rdStat(8'h00);
        memRd(1'b0, 16'h0010, '{8'h11, 8'h22, 8'h5A});
        memWr(16'h0012, '{8'hFF}, 4);
        memRd(1'b0, 16'h0012, '{8'h5A});
        memWr(16'h0010, '{8'h77}, 8, 1'b0);
        memRd(1'b0, 16'h0010, '{8'h11});
        slow <= 1'b1;
        memWr(16'h7FFF, '{8'hAA, 8'hBB});
        memRd(1'b0, 16'h7FFF, '{8'hAA, 8'hBB});
        memRd(1'b1, 16'hFFFF, '{8'hAA, 8'hBB});
        slow <= 1'b0;
        // Guard settings 1 to 3, pin low during the second array write
        for (g = 8'h01; g <= 8'h03; g++) begin
            lo = (g == 8'h01) ? 16'hDFFF : (g == 8'h02) ? 16'h3FFF : 16'h1FFF;
            wrStat(8'h00);
            memWr(lo, '{8'h10 + g, 8'h20 + g});
            wrStat({1'b1, 3'b000, g[1:0], 2'b00});
            protectN <= 1'b0;
            memWr(lo, '{8'hC0 + g, 8'hD0 + g});
            protectN <= 1'b1;
            memRd(1'b0, lo, '{(g == 8'h03) ? 8'h10 + g : 8'hC0 + g,
                              8'h20 + g});
        end
        protectN <= 1'b0;
        wrStat(8'h00);
        rdStat(8'h8C);
        protectN <= 1'b1;
        wrStat(8'h00);
        rdStat(8'h00);
        protectN <= 1'b0;
        wrStat(8'h04);
        rdStat(8'h04);
        protectN <= 1'b1;
        foreach (badOps[i]) begin
            i_snv_spi_master.open();
            sb(badOps[i], rx);
            sb(OP_STATUS_READ, rx);
            sb(8'h00, rx);
            check("float bad op", {7'h00, soOeN}, 8'h01);
            i_snv_spi_master.close();
        end
        rdStat(8'h04);
        // Mid-run reset: latch drops, guard bits are kept
        cmd(OP_LATCH_SET);
        rstn <= 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        check("float after reset", {7'h00, soOeN}, 8'h01);
        rdStat(8'h04);
        conclude();
    end
endmodule // snv_core_tb
`default_nettype wire
